/* File: verilog/nvac_params.svh */
`ifndef NVAC_PARAMS_SVH
`define NVAC_PARAMS_SVH
// i/o addresses (in/out space); data space adds the offset below
`define NVAC_IO_CTRL        6'h1F
`define NVAC_IO_DATA        6'h20
`define NVAC_IO_ADDR_LO     6'h21
`define NVAC_IO_ADDR_HI     6'h22
`define NVAC_DS_OFFSET      8'h20
`define NVAC_IO_LAST        8'h3F
`define NVAC_BIT_IO_LAST    6'h1F
`define NVAC_ADDR_W         9
`define NVAC_DEPTH          512
// control register field positions
`define NVAC_B_READ         0
`define NVAC_B_WSTROBE      1
`define NVAC_B_MASTER       2
`define NVAC_B_RIE          3
`define NVAC_B_PM_LO        4
`define NVAC_B_PM_HI        5
`define NVAC_PM_RESET       2'h0
// timing
`define NVAC_MASTER_CYC     3'h4
`define NVAC_WSTALL_CYC     3'h2
`define NVAC_RSTALL_CYC     3'h4
`define NVAC_OSC_WRITE_CYC  26368
`define NVAC_OSC_HALF_CYC   13184
`endif

/* File: verilog/nvac_pkg.sv */
package nvac_pkg;
	typedef enum logic [1:0] {
		NVAC_PM_ERASE_WRITE = 2'h0,
		NVAC_PM_ERASE_ONLY  = 2'h1,
		NVAC_PM_WRITE_ONLY  = 2'h2,
		NVAC_PM_RESERVED    = 2'h3
	} nvac_pm_e;

	typedef enum logic [1:0] {
		NVAC_IDLE   = 2'h0,
		NVAC_PROG   = 2'h1,
		NVAC_FINISH = 2'h3
	} nvac_state_e;

	// one access from the core: io instruction, load/store or single-bit op
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       io_space;
		logic       bit_op;
		logic       bit_val;
		logic [2:0] bit_sel;
		logic [7:0] addr;
		logic [7:0] wdata;
	} nvac_req_s;
endpackage : nvac_pkg

/* File: verilog/nvac_prog_timer.sv */
`timescale 1ns/100ps
`include "nvac_params.svh"
// counts rc oscillator ticks for one programming cycle
module nvac_prog_timer
(
	input  wire logic                ref_clk,
	input  wire logic                clk_en,
	input  wire logic                start,
	input  wire nvac_pkg::nvac_pm_e  mode,
	input  wire logic                osc_tick,
	output logic                     done
);
	import nvac_pkg::*;

	logic [14:0] count_reg;
	logic [14:0] limit_reg;
	logic        run_reg;
	wire  [14:0] limit_next = (mode == NVAC_PM_ERASE_WRITE) ? 15'(`NVAC_OSC_WRITE_CYC)
	                                                        : 15'(`NVAC_OSC_HALF_CYC);
	wire         hit        = run_reg && osc_tick && (count_reg == limit_reg - 15'h1);

	assign done = hit;

	always_ff @(posedge ref_clk)
	begin
		if (clk_en)
		begin
			if (start)
			begin
				run_reg   <= 1'b1;
				count_reg <= 15'h0;
				limit_reg <= limit_next;
			end
			else if (hit)
				run_reg <= 1'b0;
			else if (run_reg && osc_tick)
				count_reg <= count_reg + 15'h1;
		end
	end
endmodule : nvac_prog_timer

/* File: verilog/nvac_ctrl.sv */
`timescale 1ns/100ps
`include "nvac_params.svh"
// How it works
// (RULE_01) nine-bit linear address, upper bits read zero
// (RULE_02) control bits 7 and 6 read zero
// (RULE_03) address register not reset
// (RULE_04) data register sources writes, receives reads
// (RULE_05) mode field selects erase/write action
// (RULE_06) mode writes ignored while strobe set
// (RULE_07) mode resets to zero unless busy
// (RULE_08) ready interrupt while strobe clear, enabled
// (RULE_09) master enable self-clears after four cycles
// (RULE_10) strobe starts programming only with master
// (RULE_11) strobe stays set until programming done
// (RULE_12) write start stalls core two cycles
// (RULE_13) read fetches byte, stalls four cycles
// (RULE_14) busy blocks reads and address changes
// (RULE_15) software avoids writes during flash programming
// (RULE_16) software follows master-then-strobe sequence
// (RULE_17) write timed by rc oscillator ticks
// (RULE_18) io and data-space address windows
// (RULE_19) bit ops touch only addressed bit
// (RULE_20) software writes reserved bits as zero
// (RULE_21) read strobe clears itself
module nvac_ctrl
(
	input  wire logic                ref_clk,
	input  wire logic                rst,
	input  wire logic                clk_en,
	input  wire nvac_pkg::nvac_req_s req,
	output logic [7:0]               rdata,
	output logic                     rdata_hit,
	output logic                     core_stall,
	input  wire logic                global_irq_en,
	input  wire logic                flash_selfprog_busy,
	input  wire logic                osc_tick_pin,
	output logic                     ready_irq,
	output logic [8:0]               mem_addr,
	output logic [7:0]               mem_wdata,
	output logic                     mem_we,
	output logic [7:0]               mem_rdata_unused
);
	import nvac_pkg::*;

	// merges one bit into a byte for single-bit set and clear
	function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] s,
	                                       input logic b);
		logic [7:0] r;
		r    = v;
		r[s] = b;
		return r;
	endfunction : set_bit

	logic [7:0]  mem_reg [`NVAC_DEPTH];
	logic [8:0]  nv_byte_index_reg;
	logic [7:0]  nv_data_byte_reg;
	nvac_pm_e    prog_mode_reg;
	logic        ready_irq_enable_reg;
	logic        master_write_enable_reg;
	logic        write_strobe_reg;
	logic [2:0]  master_cnt_reg;
	logic [2:0]  stall_cnt_reg;
	nvac_state_e state_reg;
	logic        osc_s1_reg;
	logic        osc_s2_reg;
	logic        osc_s3_reg;
	logic [7:0]  rdata_reg;
	logic        rdata_hit_reg;
	logic        mem_we_reg;

	// address window decode
	wire        io_ok     = req.io_space && (req.addr <= `NVAC_IO_LAST); // RULE_18
	wire        ds_ok     = !req.io_space && (req.addr >= `NVAC_DS_OFFSET)
	                        && (req.addr <= `NVAC_IO_LAST + `NVAC_DS_OFFSET); // RULE_18
	wire [7:0]  io_sub    = req.addr - `NVAC_DS_OFFSET;
	wire [5:0]  io_addr   = req.io_space ? req.addr[5:0] : io_sub[5:0]; // RULE_18
	wire        hit_ok    = io_ok || ds_ok;
	wire        bit_ok    = !req.bit_op || (req.io_space && io_addr <= `NVAC_BIT_IO_LAST); // RULE_19
	wire        sel_ctrl  = hit_ok && (io_addr == `NVAC_IO_CTRL);
	wire        sel_data  = hit_ok && (io_addr == `NVAC_IO_DATA);
	wire        sel_alo   = hit_ok && (io_addr == `NVAC_IO_ADDR_LO);
	wire        sel_ahi   = hit_ok && (io_addr == `NVAC_IO_ADDR_HI);
	wire        busy      = write_strobe_reg;

	wire [7:0]  ctrl_view = {2'h0, prog_mode_reg, ready_irq_enable_reg, // RULE_02
	                         master_write_enable_reg, write_strobe_reg, 1'b0};
	// bit ops merge a single bit into the current value only
	wire [7:0]  ctrl_wr   = req.bit_op ? set_bit(ctrl_view, req.bit_sel, req.bit_val)
	                                   : req.wdata; // RULE_19
	wire [7:0]  data_wr   = req.bit_op ? set_bit(nv_data_byte_reg, req.bit_sel, req.bit_val)
	                                   : req.wdata;
	wire        wr_ctrl   = req.wr && sel_ctrl && bit_ok && !(req.bit_op && req.rd);
	wire        wr_ok     = req.wr && bit_ok;

	wire        strobe_set = wr_ctrl && ctrl_wr[`NVAC_B_WSTROBE] && !busy;
	wire        start_prog = strobe_set && master_write_enable_reg; // RULE_10
	wire        read_go    = wr_ctrl && ctrl_wr[`NVAC_B_READ] && !busy; // RULE_14
	wire        osc_tick   = osc_s2_reg && !osc_s3_reg;
	wire        prog_done;

	wire [7:0]  rd_mux = sel_ctrl ? ctrl_view
	                   : sel_data ? nv_data_byte_reg
	                   : sel_alo  ? nv_byte_index_reg[7:0]
	                   : sel_ahi  ? {7'h0, nv_byte_index_reg[8]} // RULE_01
	                   : 8'h0;

	assign rdata            = rdata_reg;
	assign rdata_hit        = rdata_hit_reg;
	assign core_stall       = (stall_cnt_reg != 3'h0);
	assign ready_irq        = ready_irq_enable_reg && global_irq_en // RULE_08
	                          && !write_strobe_reg && !flash_selfprog_busy;
	assign mem_addr         = nv_byte_index_reg;
	assign mem_wdata        = nv_data_byte_reg;
	assign mem_we           = mem_we_reg;
	assign mem_rdata_unused = mem_reg[nv_byte_index_reg];

	nvac_prog_timer u_timer
	(
		.ref_clk  (ref_clk),
		.clk_en   (clk_en),
		.start    (start_prog),
		.mode     (prog_mode_reg),
		.osc_tick (osc_tick),
		.done     (prog_done)
	);

	// rc oscillator is asynchronous: two-flop sync then edge detect
	always_ff @(posedge ref_clk)
	begin
		if (clk_en)
		begin
			osc_s1_reg <= osc_tick_pin;
			osc_s2_reg <= osc_s1_reg;
			osc_s3_reg <= osc_s2_reg; // RULE_17
		end
	end

	// address: no reset value, frozen while busy
	always_ff @(posedge ref_clk)
	begin
		if (clk_en && wr_ok && !busy) // RULE_14
		begin
			if (sel_alo)
				nv_byte_index_reg[7:0] <= req.bit_op
				    ? set_bit(nv_byte_index_reg[7:0], req.bit_sel, req.bit_val)
				    : req.wdata; // RULE_03
			else if (sel_ahi)
				nv_byte_index_reg[8] <= req.bit_op
				    ? (req.bit_sel == 3'h0 ? req.bit_val : nv_byte_index_reg[8])
				    : req.wdata[0]; // RULE_01
		end
	end

	// data register and the array
	always_ff @(posedge ref_clk)
	begin
		if (clk_en)
		begin
			if (read_go)
				nv_data_byte_reg <= mem_reg[nv_byte_index_reg]; // RULE_13
			else if (wr_ok && sel_data)
				nv_data_byte_reg <= data_wr; // RULE_04
			if (prog_done)
			begin
				case (prog_mode_reg)
					NVAC_PM_ERASE_WRITE: mem_reg[nv_byte_index_reg] <= nv_data_byte_reg; // RULE_05
					NVAC_PM_ERASE_ONLY:  mem_reg[nv_byte_index_reg] <= 8'hFF;
					NVAC_PM_WRITE_ONLY:  mem_reg[nv_byte_index_reg] <=
					                     mem_reg[nv_byte_index_reg] & nv_data_byte_reg;
					default:             mem_reg[nv_byte_index_reg] <= mem_reg[nv_byte_index_reg];
				endcase
			end
		end
	end

	// mode field survives reset while a write is in progress
	always_ff @(posedge ref_clk)
	begin
		if (clk_en)
		begin
			if (rst && !busy)
				prog_mode_reg <= NVAC_PM_ERASE_WRITE; // RULE_07
			else if (wr_ctrl && !busy)
				prog_mode_reg <= nvac_pm_e'(ctrl_wr[`NVAC_B_PM_HI:`NVAC_B_PM_LO]); // RULE_06
		end
	end

	// write strobe and programming sequencer
	always_ff @(posedge ref_clk)
	begin
		if (clk_en)
		begin
			mem_we_reg <= 1'b0;
			// keyed on state: the strobe flop holds no known value before the first reset
			if (rst && state_reg != NVAC_PROG)
			begin
				state_reg        <= NVAC_IDLE;
				write_strobe_reg <= 1'b0;
			end
			else
			begin
				case (state_reg)
					NVAC_IDLE:
					begin
						if (start_prog)
						begin
							write_strobe_reg <= 1'b1; // RULE_11
							state_reg        <= NVAC_PROG;
						end
					end
					NVAC_PROG:
					begin
						if (prog_done)
						begin
							mem_we_reg <= 1'b1;
							state_reg  <= NVAC_FINISH;
						end
					end
					NVAC_FINISH:
					begin
						write_strobe_reg <= 1'b0; // RULE_11
						state_reg        <= NVAC_IDLE;
					end
					default: state_reg <= NVAC_IDLE;
				endcase
			end
		end
	end

	// master enable window, interrupt enable, stall counter, read data
	always_ff @(posedge ref_clk)
	begin
		if (clk_en)
		begin
			if (rst)
			begin
				master_write_enable_reg <= 1'b0;
				master_cnt_reg          <= 3'h0;
				ready_irq_enable_reg    <= 1'b0;
				stall_cnt_reg           <= 3'h0;
				rdata_reg               <= 8'h0;
				rdata_hit_reg           <= 1'b0;
			end
			else
			begin
				if (wr_ctrl)
					ready_irq_enable_reg <= ctrl_wr[`NVAC_B_RIE];
				if (start_prog)
				begin
					master_write_enable_reg <= 1'b0;
					master_cnt_reg          <= 3'h0;
				end
				else if (wr_ctrl && ctrl_wr[`NVAC_B_MASTER] && !master_write_enable_reg)
				begin
					master_write_enable_reg <= 1'b1;
					master_cnt_reg          <= `NVAC_MASTER_CYC;
				end
				else if (master_cnt_reg == 3'h1)
				begin
					master_write_enable_reg <= 1'b0; // RULE_09
					master_cnt_reg          <= 3'h0;
				end
				else if (master_cnt_reg != 3'h0)
					master_cnt_reg <= master_cnt_reg - 3'h1;
				if (read_go)
					stall_cnt_reg <= `NVAC_RSTALL_CYC; // RULE_13 RULE_21
				else if (start_prog)
					stall_cnt_reg <= `NVAC_WSTALL_CYC; // RULE_12
				else if (stall_cnt_reg != 3'h0)
					stall_cnt_reg <= stall_cnt_reg - 3'h1;
				rdata_hit_reg <= req.rd && hit_ok;
				rdata_reg     <= (req.rd && hit_ok) ? rd_mux : 8'h0;
			end
		end
	end
endmodule : nvac_ctrl

/* File: tb/nvac_osc_model.sv */
`timescale 1ns/100ps
// free-running rc oscillator, phase unrelated to ref_clk
module nvac_osc_model
(
	output logic osc_tick
);
	initial
	begin
		osc_tick = 1'b0;
		#7.3;
		forever #26 osc_tick = ~osc_tick;
	end
endmodule : nvac_osc_model

/* File: tb/nvac_ctrl_monitor.sv */
`timescale 1ns/100ps
module nvac_ctrl_monitor
(
	input wire logic		ref_clk,
	input wire logic		rst,
	input wire logic		clk_en,
	input wire nvac_pkg::nvac_req_s	req,
	input wire logic [7:0]		rdata,
	input wire logic		rdata_hit,
	input wire logic		core_stall,
	input wire logic		global_irq_en,
	input wire logic		flash_selfprog_busy,
	input wire logic		ready_irq,
	input wire logic [8:0]		mem_addr,
	input wire logic		mem_we
);
	import nvac_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst || !clk_en);
	wire	rd_io = req.rd && req.io_space;
	sequence s_stall2; core_stall [*2] ##1 !core_stall; endsequence
	sequence s_stall4; core_stall [*4] ##1 !core_stall; endsequence
	a_stall_length: assert property ($rose(core_stall) |-> s_stall2 or s_stall4)
		else $error("stall length wrong");
	a_ctrl_reserved: assert property (rd_io && req.addr == 8'h1F |=> rdata_hit && rdata[7:6] == 2'h0 && !rdata[0])
		else $error("control reserved bits set");
	a_addr_high: assert property (req.rd && (req.io_space ? req.addr == 8'h22 : req.addr == 8'h42) |=> rdata[7:1] == 7'h00)
		else $error("address high bits set");
	a_ds_window: assert property (req.rd && !req.io_space && req.addr == 8'h3F |=> rdata_hit)
		else $error("data space read missed");
	a_unmapped_miss: assert property (req.rd && !req.io_space && req.addr == 8'h10 |=> !rdata_hit)
		else $error("unmapped read hit");
	a_irq_gate: assert property (ready_irq |-> global_irq_en && !flash_selfprog_busy)
		else $error("irq without enable");
	a_we_no_irq: assert property (mem_we |-> !ready_irq ##1 !mem_we)
		else $error("irq during write");
	a_addr_cause: assert property (mem_addr != $past(mem_addr) && !$past(rst) |-> $past(req.wr) && $past(req.addr) inside {8'h21, 8'h22, 8'h41, 8'h42})
		else $error("address changed alone");
endmodule : nvac_ctrl_monitor
bind nvac_ctrl nvac_ctrl_monitor u_mon (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
	.req(req), .rdata(rdata), .rdata_hit(rdata_hit), .core_stall(core_stall),
	.global_irq_en(global_irq_en), .flash_selfprog_busy(flash_selfprog_busy),
	.ready_irq(ready_irq), .mem_addr(mem_addr), .mem_we(mem_we));

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	import nvac_pkg::*;
	localparam logic [7:0]	k_wr = 8'hA0;
	localparam logic [7:0]	k_wd = 8'h80;
	localparam logic [7:0]	k_rd = 8'h60;
	localparam logic [7:0]	k_rs = 8'h40;
	logic		ref_clk, rst, clk_en, global_irq_en, flash_selfprog_busy, osc, pend;
	nvac_req_s	req;
	logic [7:0]	rdata, mem_wdata, mem_rd, d;
	logic		rdata_hit, core_stall, ready_irq, mem_we;
	logic [8:0]	mem_addr, a;
	logic [16:0]	note;
	logic [16:0]	exq[$];
	int		fail_count, checked, cyc;
	nvac_osc_model osc_gen (.osc_tick(osc));
	nvac_ctrl dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .req(req), .rdata(rdata),
		.rdata_hit(rdata_hit), .core_stall(core_stall), .global_irq_en(global_irq_en),
		.flash_selfprog_busy(flash_selfprog_busy), .osc_tick_pin(osc),
		.ready_irq(ready_irq), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_we(mem_we), .mem_rdata_unused(mem_rd));
	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic wrap_up();
		$display("mismatches %0d, comparisons %0d", fail_count, checked);
		if (fail_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	// k = {wr, rd, io_space, bit_op, bit_val, bit_sel}
	task automatic op(input logic [7:0] k, input logic [7:0] ad, input logic [7:0] wd);
		req <= {k, ad, wd};
		@(negedge ref_clk);
	endtask : op
	task automatic idle(input int n);
		req <= '0;
		repeat (n) @(negedge ref_clk);
	endtask : idle
	// note = {mask, hit, data}
	task automatic rd(input logic [7:0] k, input logic [7:0] ad, input logic [16:0] e);
		exq.push_back(e);
		op(k, ad, 8'h00);
	endtask : rd
	task automatic prog(input logic [1:0] m, input logic [7:0] x);
		int t0;
		int n;
		n = (m == 2'h0 ? 26368 : 13184) * 52 / 25;
		op(k_wr, 8'h20, x);
		op(k_wr, 8'h1F, {2'h0, m, 4'hC});
		op(k_wr, 8'h1F, {2'h0, m, 4'hA});
		t0 = cyc;
		cmp(core_stall, 9'h1);
		idle(1);
		cmp(core_stall, 9'h1);
		idle(1);
		cmp(core_stall, 9'h0);
		op(k_wr, 8'h1F, 8'h3B);
		cmp(core_stall, 9'h0);
		op(k_wr, 8'h21, ~a[7:0]);
		rd(k_rd, 8'h1F, {8'hFF, 1'b1, 2'h0, m, 4'hA});
		cmp(ready_irq, 9'h0);
		idle(1);
		rst <= 1'b1;
		@(negedge ref_clk);
		rst <= 1'b0;
		idle(1);
		rd(k_rd, 8'h1F, {8'hFF, 1'b1, 2'h0, m, 4'h2});
		idle(1);
		for (int i = 0; i < 60000 && mem_we !== 1'b1; i++)
			@(negedge ref_clk);
		cmp(mem_addr, a);
		cmp(mem_wdata, x);
		cmp(mem_rd, x);
		cmp(cyc - t0 >= n - 3 && cyc - t0 <= n + 8, 9'h1);
		idle(2);
		rd(k_rd, 8'h1F, {8'hFF, 1'b1, 2'h0, m, 4'h0});
		op(k_wr, 8'h20, ~x);
		op(k_wr, 8'h1F, {2'h0, m, 4'h1});
		idle(3);
		cmp(core_stall, 9'h1);
		idle(1);
		cmp(core_stall, 9'h0);
		idle(1);
		rd(k_rd, 8'h20, {8'hFF, 1'b1, x});
	endtask : prog
	always @(posedge ref_clk)
	begin
		pend <= req.rd;
		cyc++;
		if (cyc == 95000)
		begin
			fail_count++;
			wrap_up();
		end
	end
	always @(negedge ref_clk)
		if (pend === 1'b1)
		begin
			note = exq.pop_front();
			cmp(rdata_hit, note[8]);
			cmp(rdata & note[16:9], note[7:0]);
		end
	initial
	begin
		{rst, clk_en, global_irq_en, flash_selfprog_busy} = 4'hC;
		req = '0;
		void'($urandom(32'h83cc));
		repeat (10) @(negedge ref_clk);
		rst <= 1'b0;
		a = 9'($urandom);
		d = 8'($urandom);
		op(k_wr, 8'h21, a[7:0]);
		op(k_wd, 8'h42, {7'h55, a[8]});
		op(k_wr, 8'h20, d);
		rd(k_rd, 8'h21, {8'hFF, 1'b1, a[7:0]});
		rd(k_rs, 8'h42, {8'hFF, 1'b1, 7'h0, a[8]});
		rd(k_rd, 8'h20, {8'hFF, 1'b1, d});
		rd(k_rs, 8'h10, 17'h0);
		for (int m = 0; m < 4; m++)
		begin
			op(k_wr, 8'h1F, {2'h3, m[1:0], 4'h0});
			rd(k_rs, 8'h3F, {8'hFF, 1'b1, 2'h0, m[1:0], 4'h0});
		end
		op(8'hBB, 8'h1F, 8'h00);
		op({4'hB, ~a[0], 3'h0}, 8'h21, 8'h00);
		rd(k_rd, 8'h1F, {8'hFF, 1'b1, 8'h38});
		rd(k_rd, 8'h21, {8'hFF, 1'b1, a[7:0]});
		clk_en <= 1'b0;
		op(k_wr, 8'h21, ~a[7:0]);
		clk_en <= 1'b1;
		rd(k_rd, 8'h21, {8'hFF, 1'b1, a[7:0]});
		global_irq_en <= 1'b1;
		idle(1);
		cmp(ready_irq, 9'h1);
		op(k_wr, 8'h1F, 8'h0C);
		idle(5);
		op(k_wr, 8'h1F, 8'h0A);
		rd(k_rd, 8'h1F, {8'hFF, 1'b1, 8'h08});
		prog(2'h1, 8'hFF);
		prog(2'h0, d);
		op(8'hBB, 8'h1F, 8'h00);
		idle(1);
		cmp(ready_irq, 9'h1);
		flash_selfprog_busy <= 1'b1;
		idle(1);
		cmp(ready_irq, 9'h0);
		wrap_up();
	end
endmodule : tb_top
